//--- hdl/pmbus_telemetry_status.sv
// command interpreter, telemetry correction and fault status for the power module
// assumes one decoded command per cmd_valid pulse and synchronous sensor inputs
`timescale 1ns/1ps
module pmbus_telemetry_status import pmbus_telemetry_pkg::*; #(
    parameter int STORE_WAIT_CYCLES = STORE_WAIT_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire cmd_req_t cmd_req,
    output logic rsp_valid,
    output cmd_rsp_t rsp,
    input wire adc_sample_t adc,
    input wire factory_cal_t cal,
    input wire fault_events_t events,
    input wire logic power_not_good,
    input wire logic onoff_pin_on,
    input wire logic onoff_cmd_honoured,
    input wire logic [15:0] soft_start_delay,
    input wire logic [15:0] soft_start_rise,
    input wire logic nvm_done,
    output logic nvm_store_req,
    output nvm_image_t nvm_image,
    output logic store_busy,
    output logic output_enable,
    output logic [15:0] vout_target,
    output logic margin_low_active,
    output logic margin_high_active
);
    logic [15:0] setpoint;
    logic [15:0] margin_high;
    logic [15:0] margin_low;
    logic op_on;
    logic [1:0] op_margin;
    logic [FLAG_COUNT-1:0] flags;
    logic [FLAG_COUNT-1:0] set_flags;
    logic [15:0] vout_word;
    logic [15:0] vin_word;
    logic [15:0] iout_word;
    logic [15:0] temp_word;
    store_state_t store_state;
    logic [24:0] store_count;

    // command decode
    wire is_write = cmd_valid & cmd_req.write;
    wire is_read = cmd_valid & ~cmd_req.write;
    wire pec_ok = ~cmd_req.pec_bad;
    wire busy_now = (store_state == STORE_BUSY);
    wire code_rw = (cmd_req.code == CMD_OPERATION) | (cmd_req.code == CMD_VOUT_SET)
        | (cmd_req.code == CMD_MARGIN_HIGH) | (cmd_req.code == CMD_MARGIN_LOW);
    wire code_wo = (cmd_req.code == CMD_CLEAR_FAULTS) | (cmd_req.code == CMD_STORE_ALL);
    wire code_ro = (cmd_req.code == CMD_VOUT_MODE) | (cmd_req.code == CMD_SUMMARY)
        | (cmd_req.code == CMD_VOUT_FLAGS) | (cmd_req.code == CMD_IOUT_FLAGS)
        | (cmd_req.code == CMD_INPUT_FLAGS) | (cmd_req.code == CMD_THERMAL_FLAGS)
        | (cmd_req.code == CMD_COMM_FLAGS) | (cmd_req.code == CMD_READ_VIN)
        | (cmd_req.code == CMD_READ_VOUT) | (cmd_req.code == CMD_READ_IOUT)
        | (cmd_req.code == CMD_READ_TEMP) | (cmd_req.code == CMD_OUT_TRIM)
        | (cmd_req.code == CMD_IN_TRIM) | (cmd_req.code == CMD_IN_SCALE)
        | (cmd_req.code == CMD_CUR_TRIM) | (cmd_req.code == CMD_CUR_SCALE);
    wire bad_cmd = cmd_valid & pec_ok & ((cmd_req.write & ~code_rw & ~code_wo)
        | (~cmd_req.write & ~code_rw & ~code_ro));
    // writes are only taken while no store is in flight
    wire wr_ok = is_write & pec_ok & ~busy_now;
    wire data_in_range = (cmd_req.data >= VOUT_MIN) & (cmd_req.data <= VOUT_MAX);
    wire wr_volt = wr_ok & ((cmd_req.code == CMD_VOUT_SET) | (cmd_req.code == CMD_MARGIN_HIGH)
        | (cmd_req.code == CMD_MARGIN_LOW));
    wire wr_op = wr_ok & (cmd_req.code == CMD_OPERATION);
    wire [1:0] op_margin_in = cmd_req.data[5:4];
    wire bad_data = (wr_volt & ~data_in_range) | (wr_op & (op_margin_in == MARGIN_BAD));
    wire take_setpoint = wr_ok & (cmd_req.code == CMD_VOUT_SET) & data_in_range;
    wire take_high = wr_ok & (cmd_req.code == CMD_MARGIN_HIGH) & data_in_range;
    wire take_low = wr_ok & (cmd_req.code == CMD_MARGIN_LOW) & data_in_range;
    wire take_op = wr_op & (op_margin_in != MARGIN_BAD);
    wire clear_all = wr_ok & (cmd_req.code == CMD_CLEAR_FAULTS);
    wire start_store = wr_ok & (cmd_req.code == CMD_STORE_ALL) & ~busy_now;
    wire refuse = cmd_valid & (cmd_req.pec_bad | bad_cmd | bad_data | (is_write & busy_now));

    // setpoint and margin registers, rejected values leave the old one
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            setpoint <= SETPOINT_DEFAULT;
            margin_high <= MARGIN_HIGH_DEFAULT;
            margin_low <= MARGIN_LOW_DEFAULT;
        end else begin
            if (take_setpoint) setpoint <= cmd_req.data;
            if (take_high) margin_high <= cmd_req.data;
            if (take_low) margin_low <= cmd_req.data;
        end
    end

    // operation byte: on bit and margin field, bits 3:2 fixed
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            op_on <= 1'b1;
            op_margin <= MARGIN_OFF;
        end else if (take_op) begin
            op_on <= cmd_req.data[OP_ON_BIT];
            op_margin <= op_margin_in;
        end
    end

    // output control derived from operation byte
    wire next_output_enable = (op_on | ~onoff_cmd_honoured) & onoff_pin_on;
    wire next_margin_low = (op_margin == MARGIN_LOW);
    wire next_margin_high = (op_margin == MARGIN_HIGH);
    wire [15:0] next_vout_target = next_margin_low ? margin_low :
        (next_margin_high ? margin_high : setpoint);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            output_enable <= 1'b0;
            margin_low_active <= 1'b0;
            margin_high_active <= 1'b0;
            vout_target <= SETPOINT_DEFAULT;
        end else begin
            output_enable <= next_output_enable;
            margin_low_active <= next_margin_low;
            margin_high_active <= next_margin_high;
            vout_target <= next_vout_target;
        end
    end

    // output voltage correction with clamping to unsigned range
    wire [17:0] vout_sum = {2'b00, adc.vout} + {{2{cal.out_trim[15]}}, cal.out_trim};
    wire [15:0] next_vout_word = vout_sum[17] ? 16'h0000 :
        (vout_sum[16] ? 16'hFFFF : vout_sum[15:0]);
    // input voltage gain and trim
    wire [26:0] vin_prod = {16'h0000, adc.vin} * {11'h000, cal.in_scale};
    wire [13:0] vin_scaled = 14'(vin_prod >> GAIN_SHIFT);
    wire [15:0] vin_sum = {2'b00, vin_scaled} + {{5{cal.in_trim[10]}}, cal.in_trim};
    wire [9:0] vin_mant = vin_sum[15] ? 10'h000 :
        ((vin_sum[14:0] > {5'h00, MANT_POS_MAX}) ? MANT_POS_MAX : vin_sum[9:0]);
    // output current gain, trim, sink and blanking
    wire iout_neg = adc.iout[10] | adc.sinking;
    wire [25:0] iout_prod = {16'h0000, adc.iout[9:0]} * {10'h000, cal.cur_scale};
    wire [12:0] iout_scaled = 13'(iout_prod >> GAIN_SHIFT);
    wire [14:0] iout_sum = {2'b00, iout_scaled} + {{4{cal.cur_trim[10]}}, cal.cur_trim};
    wire [9:0] iout_clamp = iout_sum[14] ? 10'h000 :
        ((iout_sum[13:0] > {4'h0, MANT_POS_MAX}) ? MANT_POS_MAX : iout_sum[9:0]);
    wire [9:0] iout_mant = (iout_neg | (iout_clamp < IOUT_BLANK_MANT)) ? 10'h000 : iout_clamp;

    // telemetry words, refreshed every cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            vout_word <= 16'h0000;
            vin_word <= {EXP_VIN, 11'h000};
            iout_word <= {EXP_IOUT, 11'h000};
            temp_word <= {EXP_TEMP, 11'h000};
        end else begin
            vout_word <= next_vout_word;
            vin_word <= {EXP_VIN, 1'b0, vin_mant};
            iout_word <= {EXP_IOUT, 1'b0, iout_mant};
            temp_word <= {EXP_TEMP, adc.temp};
        end
    end

    // event sources for sticky flags
    assign set_flags[FLG_VOUT_OV] = events.vout_ov;
    assign set_flags[FLG_IOUT_OC] = events.iout_oc;
    assign set_flags[FLG_IOUT_WARN] = events.iout_oc_warn;
    assign set_flags[FLG_VIN_OV] = events.vin_ov;
    assign set_flags[FLG_VIN_UV] = events.vin_uv;
    assign set_flags[FLG_VIN_OFF] = events.vin_low_off;
    assign set_flags[FLG_OT_FAULT] = events.ot_fault;
    assign set_flags[FLG_OT_WARN] = events.ot_warn;
    assign set_flags[FLG_CML_CMD] = bad_cmd;
    assign set_flags[FLG_CML_DATA] = bad_data;
    assign set_flags[FLG_CML_PEC] = cmd_valid & cmd_req.pec_bad;

    // sticky flags, a set in the clearing cycle wins
    generate
        for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) flags[i] <= 1'b0;
                else flags[i] <= set_flags[i] | (flags[i] & ~clear_all);
            end
        end
    endgenerate

    // status bytes, unsupported bits tied low
    wire [7:0] vout_flags = {flags[FLG_VOUT_OV], 7'h00};
    wire [7:0] iout_flags = {flags[FLG_IOUT_OC], 1'b0, flags[FLG_IOUT_WARN], 5'h00};
    wire [7:0] input_flags = {flags[FLG_VIN_OV], 2'b00, flags[FLG_VIN_UV],
        flags[FLG_VIN_OFF], 3'h0};
    wire [7:0] thermal_flags = {flags[FLG_OT_FAULT], flags[FLG_OT_WARN], 6'h00};
    wire [7:0] comm_flags = {flags[FLG_CML_CMD], flags[FLG_CML_DATA], flags[FLG_CML_PEC], 5'h00};
    wire [7:0] summary_hi = {|vout_flags, |iout_flags, |input_flags, 1'b0,
        power_not_good, 3'h0};
    wire [7:0] summary_lo = {1'b0, ~output_enable, flags[FLG_VOUT_OV], flags[FLG_IOUT_OC],
        flags[FLG_VIN_UV], |thermal_flags, |comm_flags, 1'b0};
    wire [7:0] op_byte = {op_on, 1'b0, op_margin, OP_FIXED_32, 2'b00};

    // read data selection
    wire [7:0] rc = cmd_req.code;
    wire [15:0] read_data =
        (rc == CMD_OPERATION) ? {8'h00, op_byte} :
        (rc == CMD_VOUT_MODE) ? {8'h00, VOUT_MODE_VAL} :
        (rc == CMD_VOUT_SET) ? setpoint :
        (rc == CMD_MARGIN_HIGH) ? margin_high :
        (rc == CMD_MARGIN_LOW) ? margin_low :
        (rc == CMD_SUMMARY) ? {summary_hi, summary_lo} :
        (rc == CMD_VOUT_FLAGS) ? {8'h00, vout_flags} :
        (rc == CMD_IOUT_FLAGS) ? {8'h00, iout_flags} :
        (rc == CMD_INPUT_FLAGS) ? {8'h00, input_flags} :
        (rc == CMD_THERMAL_FLAGS) ? {8'h00, thermal_flags} :
        (rc == CMD_COMM_FLAGS) ? {8'h00, comm_flags} :
        (rc == CMD_READ_VIN) ? vin_word :
        (rc == CMD_READ_VOUT) ? vout_word :
        (rc == CMD_READ_IOUT) ? iout_word :
        (rc == CMD_READ_TEMP) ? temp_word :
        (rc == CMD_OUT_TRIM) ? cal.out_trim :
        (rc == CMD_IN_TRIM) ? {EXP_VIN, cal.in_trim} :
        (rc == CMD_IN_SCALE) ? cal.in_scale :
        (rc == CMD_CUR_TRIM) ? {EXP_IOUT, cal.cur_trim} :
        (rc == CMD_CUR_SCALE) ? cal.cur_scale : 16'h0000;
    wire [15:0] next_rsp_data = (is_read & ~refuse) ? read_data : 16'h0000;

    // one answer per command, one cycle later
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= cmd_valid;
            rsp.data <= next_rsp_data;
            rsp.refused <= refuse;
        end
    end

    // store sequencer: ends on memory done or on the worst-case time
    wire store_timeout = (store_count >= 25'(STORE_WAIT_CYCLES - 1));
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            store_state <= STORE_IDLE;
            store_count <= 25'h0000000;
        end else begin
            case (store_state)
                STORE_IDLE: begin
                    store_count <= 25'h0000000;
                    if (start_store) store_state <= STORE_BUSY;
                end
                STORE_BUSY: begin
                    store_count <= store_count + 25'h0000001;
                    if (nvm_done | store_timeout) store_state <= STORE_IDLE;
                end
                default: store_state <= STORE_IDLE;
            endcase
        end
    end

    // store request and image capture
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nvm_store_req <= 1'b0;
            nvm_image <= '0;
            store_busy <= 1'b0;
        end else begin
            nvm_store_req <= start_store;
            store_busy <= (store_state == STORE_BUSY) ? ~(nvm_done | store_timeout) : start_store;
            if (start_store) nvm_image <= {setpoint, margin_high, margin_low,
                soft_start_delay, soft_start_rise};
        end
    end

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_store_begin;
        start_store ##1 nvm_store_req;
    endsequence

    a_setpoint_range: assert property ((setpoint >= VOUT_MIN) && (setpoint <= VOUT_MAX))
        else $error("setpoint left its permitted range");
    a_bad_value_kept: assert property (wr_ok && (cmd_req.code == CMD_VOUT_SET) && !data_in_range
        |=> (setpoint == $past(setpoint)) && flags[FLG_CML_DATA])
        else $error("out of range setpoint was taken or not flagged");
    a_margin_select: assert property ($rose(margin_low_active)
        |-> vout_target == $past(margin_low))
        else $error("margin low did not drive the target");
    a_vout_readback: assert property (is_read && pec_ok && (cmd_req.code == CMD_READ_VOUT)
        |=> rsp_valid && (rsp.data == $past(vout_word)))
        else $error("output voltage reading mismatched");
    a_iout_blanked: assert property ((iout_word[10:0] == 11'h000)
        || (iout_word[9:0] >= IOUT_BLANK_MANT && !iout_word[10]))
        else $error("current below blanking level reported");
    a_iout_sinking: assert property (adc.sinking |=> iout_word == {EXP_IOUT, 11'h000})
        else $error("sinking current reported nonzero");
    a_vin_format: assert property (vin_word[15:11] == EXP_VIN && !vin_word[10])
        else $error("input voltage word badly formed");
    a_store_copy: assert property (s_store_begin
        |-> (nvm_image.setpoint == $past(setpoint)) && (nvm_image.margin_low == $past(margin_low)))
        else $error("store image did not capture the setpoint");
    a_store_busy: assert property (s_store_begin |-> store_busy)
        else $error("busy not raised during store");
    a_flag_sticky: assert property (events.iout_oc |=> flags[FLG_IOUT_OC] ##1
        (flags[FLG_IOUT_OC] || $past(clear_all)))
        else $error("current fault flag lost");
    a_reserved_zero: assert property (is_read && pec_ok && (cmd_req.code == CMD_VOUT_FLAGS)
        |=> rsp.data[6:0] == 7'h00)
        else $error("unsupported status bit read as one");
    a_output_switch: assert property (onoff_pin_on && onoff_cmd_honoured && !op_on
        |=> !output_enable)
        else $error("output stayed on while commanded off");
endmodule

//--- hdl/pmbus_telemetry_pkg.sv
// constants, field layouts and carrier types for the power-module command block
// assumes the serial link layer outside delivers whole decoded commands
// Summary of operation
// - setpoint is unsigned mantissa, exponent -12
// - setpoint limited 8.10 V to 13.20 V
// - store-all copies setpoint, margins, soft-start values
// - margin levels use linear exponent -12
// - operation bits 5:4 select margin state
// - output voltage reads unsigned mantissa, exponent -12
// - output reading adds signed readable factory trim
// - input reading: exponent -3, positive mantissa
// - input reading scaled by gain/8192 plus trim
// - current reading: exponent -4, positive mantissa
// - current below 1.65 A reads zero
// - current reading scaled by gain/8192 plus trim
// - sinking current reads as zero
// - temperature reads signed mantissa, exponent -2
// - summary high byte fault bits
// - summary low byte fault bits
// - unsupported status bits always read zero
// - output voltage status: overvoltage bit only
// - current status: fault and warning bits
// - input status: overvoltage, undervoltage, low-input off
// - thermal status: fault and warning bits
// - comm status: command, data, checksum bits
// - store takes up to 500 ms, host waits
// - operation bit 7 switches output on/off
package pmbus_telemetry_pkg;
    // command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STORE_ALL = 8'h11;
    localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
    localparam logic [7:0] CMD_VOUT_SET = 8'h21;
    localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
    localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
    localparam logic [7:0] CMD_SUMMARY = 8'h79;
    localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7A;
    localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7B;
    localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7C;
    localparam logic [7:0] CMD_THERMAL_FLAGS = 8'h7D;
    localparam logic [7:0] CMD_COMM_FLAGS = 8'h7E;
    localparam logic [7:0] CMD_READ_VIN = 8'h88;
    localparam logic [7:0] CMD_READ_VOUT = 8'h8B;
    localparam logic [7:0] CMD_READ_IOUT = 8'h8C;
    localparam logic [7:0] CMD_READ_TEMP = 8'h8D;
    localparam logic [7:0] CMD_OUT_TRIM = 8'hD0;
    localparam logic [7:0] CMD_IN_TRIM = 8'hD1;
    localparam logic [7:0] CMD_IN_SCALE = 8'hD2;
    localparam logic [7:0] CMD_CUR_TRIM = 8'hD3;
    localparam logic [7:0] CMD_CUR_SCALE = 8'hD4;
    // output voltage format and limits
    localparam logic [7:0] VOUT_MODE_VAL = 8'h14;
    localparam logic [15:0] VOUT_MIN = 16'h819A;
    localparam logic [15:0] VOUT_MAX = 16'hD333;
    localparam logic [15:0] SETPOINT_DEFAULT = 16'hC000;
    localparam logic [15:0] MARGIN_HIGH_DEFAULT = 16'hC99A;
    localparam logic [15:0] MARGIN_LOW_DEFAULT = 16'hB666;
    // linear11 exponents and mantissa limits
    localparam logic [4:0] EXP_VIN = 5'h1D;
    localparam logic [4:0] EXP_IOUT = 5'h1C;
    localparam logic [4:0] EXP_TEMP = 5'h1E;
    localparam logic [9:0] MANT_POS_MAX = 10'h3FF;
    localparam logic [9:0] IOUT_BLANK_MANT = 10'h01B;
    localparam int GAIN_SHIFT = 13;
    // operation byte layout
    localparam int OP_ON_BIT = 7;
    localparam logic [1:0] OP_FIXED_32 = 2'h2;
    localparam logic [1:0] MARGIN_OFF = 2'h0;
    localparam logic [1:0] MARGIN_LOW = 2'h1;
    localparam logic [1:0] MARGIN_HIGH = 2'h2;
    localparam logic [1:0] MARGIN_BAD = 2'h3;
    // sticky flag indices
    localparam int FLG_VOUT_OV = 0;
    localparam int FLG_IOUT_OC = 1;
    localparam int FLG_IOUT_WARN = 2;
    localparam int FLG_VIN_OV = 3;
    localparam int FLG_VIN_UV = 4;
    localparam int FLG_VIN_OFF = 5;
    localparam int FLG_OT_FAULT = 6;
    localparam int FLG_OT_WARN = 7;
    localparam int FLG_CML_CMD = 8;
    localparam int FLG_CML_DATA = 9;
    localparam int FLG_CML_PEC = 10;
    localparam int FLAG_COUNT = 11;
    // store timing
    localparam int STORE_TIME_MS = 500;
    localparam int CLK_HZ = 50000000;
    localparam int STORE_WAIT_DEFAULT = STORE_TIME_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic [15:0] data;
        logic pec_bad;
    } cmd_req_t;
    typedef struct packed {
        logic [15:0] data;
        logic refused;
    } cmd_rsp_t;
    typedef struct packed {
        logic vout_ov;
        logic iout_oc;
        logic iout_oc_warn;
        logic vin_ov;
        logic vin_uv;
        logic vin_low_off;
        logic ot_fault;
        logic ot_warn;
    } fault_events_t;
    typedef struct packed {
        logic [15:0] out_trim;
        logic [10:0] in_trim;
        logic [15:0] in_scale;
        logic [10:0] cur_trim;
        logic [15:0] cur_scale;
    } factory_cal_t;
    typedef struct packed {
        logic [15:0] vout;
        logic [10:0] vin;
        logic [10:0] iout;
        logic [10:0] temp;
        logic sinking;
    } adc_sample_t;
    typedef struct packed {
        logic [15:0] setpoint;
        logic [15:0] margin_high;
        logic [15:0] margin_low;
        logic [15:0] ton_delay;
        logic [15:0] ton_rise;
    } nvm_image_t;
    typedef enum logic [1:0] {
        STORE_IDLE = 2'b01,
        STORE_BUSY = 2'b10
    } store_state_t;
endpackage

//--- verif/nvm_model.sv
// non-volatile memory stand-in for the store path
// assumes one store request pulse at a time from the command block
`timescale 1ns/1ps
module nvm_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic nvm_store_req,
    output logic nvm_done
);
    logic [3:0] busy_cnt;
    // program time, then one done pulse well inside the store window
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt <= 4'h0;
            nvm_done <= 1'b0;
        end else begin
            nvm_done <= (busy_cnt == 4'h1);
            busy_cnt <= nvm_store_req ? 4'hA : (busy_cnt != 4'h0 ? busy_cnt - 4'h1 : 4'h0);
        end
    end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the command, telemetry and status block
// assumes the nvm stand-in answers store requests
`timescale 1ns/1ps
module tb_top;
    import pmbus_telemetry_pkg::*;
    logic clk_sys = 0, arst_n = 0, cmd_valid = 0, power_not_good = 0, onoff_pin_on = 1, onoff_cmd_honoured = 1;
    logic nvm_done, rsp_valid, nvm_store_req, store_busy, output_enable, margin_low_active, margin_high_active;
    cmd_req_t cmd_req = '0;
    adc_sample_t adc = '0;
    factory_cal_t cal = '0;
    fault_events_t events = '0;
    cmd_rsp_t rsp;
    nvm_image_t nvm_image;
    logic [15:0] vout_target;
    int error_cnt = 0, cmp_count = 0, cycles = 0;
    logic [7:0] ev_code [8] = '{8'h7A, 8'h7B, 8'h7B, 8'h7C, 8'h7C, 8'h7C, 8'h7D, 8'h7D};
    logic [7:0] ev_val [8] = '{8'h80, 8'h80, 8'h20, 8'h80, 8'h10, 8'h08, 8'h80, 8'h40};
    pmbus_telemetry_status #(.STORE_WAIT_CYCLES(16)) DUT (.clk_sys(clk_sys), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_req(cmd_req), .rsp_valid(rsp_valid), .rsp(rsp), .adc(adc), .cal(cal),
        .events(events), .power_not_good(power_not_good), .onoff_pin_on(onoff_pin_on),
        .onoff_cmd_honoured(onoff_cmd_honoured), .soft_start_delay(16'h0014), .soft_start_rise(16'h001E),
        .nvm_done(nvm_done), .nvm_store_req(nvm_store_req), .nvm_image(nvm_image), .store_busy(store_busy),
        .output_enable(output_enable), .vout_target(vout_target), .margin_low_active(margin_low_active),
        .margin_high_active(margin_high_active));
    nvm_model mem (.clk_sys(clk_sys), .arst_n(arst_n), .nvm_store_req(nvm_store_req), .nvm_done(nvm_done));
    always #10 clk_sys = ~clk_sys;
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(string name, logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    // one command, then wait for its single response
    task automatic cmd(logic w, logic [7:0] c, logic [15:0] d, logic pb);
        int n;
        n = 0;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_req = '{w, c, d, pb};
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 3) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 3) check("response strobe", 16'h0000, 16'h0001);
    endtask
    task automatic rd(logic [7:0] c, logic [15:0] exp, string name);
        cmd(1'b0, c, 16'h0000, 1'b0);
        check(name, rsp.data, exp);
    endtask
    task automatic wr(logic [7:0] c, logic [15:0] d, logic refused, string name);
        cmd(1'b1, c, d, 1'b0);
        check(name, {15'h0, rsp.refused}, {15'h0, refused});
    endtask
    task automatic settle(logic [15:0] exp, string name);
        repeat (3) @(negedge clk_sys);
        check(name, vout_target, exp);
    endtask
    task automatic t_reset();
        rd(CMD_OPERATION, 16'h0088, "operation default");
        rd(CMD_VOUT_MODE, 16'h0014, "output format");
        rd(CMD_SUMMARY, 16'h0000, "summary default");
        check("target default", vout_target, 16'hC000);
    endtask
    task automatic t_setpoint();
        wr(CMD_VOUT_SET, 16'hD333, 1'b0, "top of range");
        wr(CMD_VOUT_SET, 16'hD334, 1'b1, "above range");
        rd(CMD_VOUT_SET, 16'hD333, "kept setpoint");
        wr(CMD_VOUT_SET, 16'h8199, 1'b1, "below range");
        rd(CMD_COMM_FLAGS, 16'h0040, "bad data flag");
        wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0, "clear");
        wr(CMD_VOUT_SET, 16'hC800, 1'b0, "setpoint");
        settle(16'hC800, "target");
    endtask
    task automatic t_margin();
        wr(CMD_MARGIN_HIGH, 16'hCC00, 1'b0, "margin high");
        wr(CMD_MARGIN_LOW, 16'h9000, 1'b0, "margin low");
        wr(CMD_OPERATION, 16'h00A8, 1'b0, "op high");
        settle(16'hCC00, "target high");
        check("high active", {15'h0, margin_high_active}, 16'h0001);
        wr(CMD_OPERATION, 16'h0098, 1'b0, "op low");
        settle(16'h9000, "target low");
        check("low active", {15'h0, margin_low_active}, 16'h0001);
        wr(CMD_OPERATION, 16'h0088, 1'b0, "op off");
        settle(16'hC800, "target off");
        wr(CMD_OPERATION, 16'h0008, 1'b0, "op disable");
        settle(16'hC800, "target kept");
        check("enable", {15'h0, output_enable}, 16'h0000);
        rd(CMD_SUMMARY, 16'h0040, "summary off");
        onoff_cmd_honoured = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("on bit ignored", {15'h0, output_enable}, 16'h0001);
        onoff_cmd_honoured = 1'b1;
        wr(CMD_OPERATION, 16'h0088, 1'b0, "op enable");
    endtask
    task automatic t_telemetry();
        adc = '{16'hC000, 11'h180, 11'h0A0, 11'h7F0, 1'b0};
        cal = '{16'hFF00, 11'h008, 16'h4000, 11'h002, 16'h4000};
        repeat (3) @(negedge clk_sys);
        rd(CMD_READ_VOUT, 16'hBF00, "vout");
        rd(CMD_READ_VIN, 16'hEB08, "vin");
        rd(CMD_READ_IOUT, 16'hE142, "iout");
        rd(CMD_READ_TEMP, 16'hF7F0, "temp");
        rd(CMD_OUT_TRIM, 16'hFF00, "out trim");
        rd(CMD_IN_SCALE, 16'h4000, "in scale");
        rd(CMD_CUR_TRIM, 16'hE002, "cur trim");
        adc.iout = 11'h005;
        repeat (3) @(negedge clk_sys);
        cmd(1'b0, CMD_READ_IOUT, 16'h0000, 1'b0);
        check("blanked iout", {5'h00, rsp.data[10:0]}, 16'h0000);
        adc.iout = 11'h0A0;
        adc.sinking = 1'b1;
        repeat (3) @(negedge clk_sys);
        cmd(1'b0, CMD_READ_IOUT, 16'h0000, 1'b0);
        check("sinking iout", {5'h00, rsp.data[10:0]}, 16'h0000);
    endtask
    task automatic t_events();
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            events = fault_events_t'(8'h80 >> i);
            @(negedge clk_sys);
            events = '0;
            if (i == 0) rd(CMD_SUMMARY, 16'h8020, "summary vout");
            rd(ev_code[i], {8'h00, ev_val[i]}, "status byte");
            wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0, "clear");
        end
    endtask
    task automatic t_comm();
        power_not_good = 1'b1;
        rd(CMD_SUMMARY, 16'h0800, "power not good");
        power_not_good = 1'b0;
        rd(8'h55, 16'h0000, "unknown code");
        rd(CMD_COMM_FLAGS, 16'h0080, "bad command flag");
        wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0, "clear");
        cmd(1'b1, CMD_VOUT_SET, 16'hC000, 1'b1);
        check("pec refused", {15'h0, rsp.refused}, 16'h0001);
        rd(CMD_COMM_FLAGS, 16'h0020, "pec flag");
        wr(CMD_OPERATION, 16'h00B8, 1'b1, "bad margin");
        rd(CMD_OPERATION, 16'h0088, "operation kept");
        rd(CMD_COMM_FLAGS, 16'h0060, "bad margin flag");
        wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0, "clear");
    endtask
    task automatic t_store();
        int n;
        n = 0;
        wr(CMD_STORE_ALL, 16'h0000, 1'b0, "store");
        check("store request", {15'h0, nvm_store_req}, 16'h0001);
        wr(CMD_VOUT_SET, 16'hC000, 1'b1, "write while busy");
        while (store_busy !== 1'b0 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        check("store end", {15'h0, store_busy}, 16'h0000);
        check("saved setpoint", nvm_image.setpoint, 16'hC800);
        check("saved high", nvm_image.margin_high, 16'hCC00);
        check("saved low", nvm_image.margin_low, 16'h9000);
        check("saved delay", nvm_image.ton_delay, 16'h0014);
        check("saved rise", nvm_image.ton_rise, 16'h001E);
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        t_reset();
        t_setpoint();
        t_margin();
        t_telemetry();
        t_events();
        t_comm();
        t_store();
        report_and_stop();
    end
endmodule
